/* rtl/rlcr_pkg.sv */
/*
 * constants of the lane configuration register bank: offsets, write masks,
 * reset values, field positions, slave address layout and strap decode.
 * assumes nothing of its surroundings; imported by no file, used by scope.
 */
package rlcr_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFF_SOFT_RST  = 8'h00; // soft_reset_ctrl
	localparam logic [7:0] OFF_LANE_PD   = 8'h01; // lane_power_down
	localparam logic [7:0] OFF_PD_SRC    = 8'h02; // power_down_source
	localparam logic [7:0] OFF_OVERRIDE  = 8'h08; // strap_override
	localparam logic [7:0] OFF_IDLE_RATE = 8'h0e; // lane0_b_idle_rate_ctrl
	localparam logic [7:0] OFF_EQ        = 8'h0f; // lane0_b_equalizer
	localparam logic [7:0] OFF_SWING     = 8'h10; // lane0_b_output_swing

	// ************************************************************
	// writable bits; reserved bits are never stored and read as zero
	// ************************************************************
	localparam logic [7:0] MSK_LANE_PD   = 8'hff;
	localparam logic [7:0] MSK_PD_SRC    = 8'h01;
	localparam logic [7:0] MSK_OVERRIDE  = 8'h14;
	localparam logic [7:0] MSK_IDLE_RATE = 8'h33;
	localparam logic [7:0] MSK_EQ        = 8'h3f;
	localparam logic [7:0] MSK_SWING     = 8'h7f;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_LANE_PD   = 8'h00;
	localparam logic [7:0] RST_PD_SRC    = 8'h00;
	localparam logic [7:0] RST_OVERRIDE  = 8'h00;
	localparam logic [7:0] RST_IDLE_RATE = 8'h00;
	localparam logic [7:0] RST_EQ        = 8'h20; // bypass
	localparam logic [7:0] RST_SWING     = 8'h03; // 600 mV

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_SOFT_RST   = 0;
	localparam int BIT_PD_BLOCK   = 0;
	localparam int BIT_OVR_IDLE   = 4;
	localparam int BIT_OVR_RATE   = 2;
	localparam int BIT_IDLE_AUTO  = 5;
	localparam int BIT_IDLE_MUTE  = 4;
	localparam int BIT_RATE_AUTO  = 1;
	localparam int BIT_RATE_FAST  = 0;
	localparam int BIT_EQ_EN      = 5;

	// ************************************************************
	// slave address: fixed upper three bits, address straps below
	// ************************************************************
	localparam logic [2:0] SLAVE_ADDR_HI = 3'h5;

	// ************************************************************
	// three-level strap codes and their equalizer equivalents
	// ************************************************************
	localparam logic [1:0] STRAP_LOW   = 2'h0;
	localparam logic [1:0] STRAP_HIGH  = 2'h1;
	localparam logic [1:0] STRAP_FLOAT = 2'h2;

	// map the two equalizer straps onto the register encoding
	function automatic logic [7:0] eq_from_straps(input logic [1:0] hi, input logic [1:0] lo);
		logic [3:0] key;
		key = {hi, lo};
		case (key)
			{STRAP_HIGH,  STRAP_HIGH}:  eq_from_straps = 8'h2a;
			{STRAP_LOW,   STRAP_LOW}:   eq_from_straps = 8'h30;
			{STRAP_FLOAT, STRAP_LOW}:   eq_from_straps = 8'h32;
			{STRAP_HIGH,  STRAP_LOW}:   eq_from_straps = 8'h39;
			{STRAP_FLOAT, STRAP_HIGH}:  eq_from_straps = 8'h35;
			{STRAP_LOW,   STRAP_HIGH}:  eq_from_straps = 8'h37;
			{STRAP_LOW,   STRAP_FLOAT}: eq_from_straps = 8'h3b;
			{STRAP_HIGH,  STRAP_FLOAT}: eq_from_straps = 8'h3d;
			default:                    eq_from_straps = RST_EQ; // both floating: bypass
		endcase
	endfunction

endpackage

/* rtl/rlcr_regbank.sv */
/*
 * smbus byte slave plus the lane configuration register bank, with the
 * pin/register arbitration for power-down, idle, rate and equalizer.
 * assumes scl is no faster than about a tenth of the core clock, and
 * that all pin inputs are asynchronous levels.
 */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1: bit0 write at 0x00 restores all defaults
// R2: 0x01 holds per-lane power-down bits
// R3: 0x02 bit0 blocks power-down pin
// R4: 0x08 bit4 blocks idle pin
// R5: 0x08 bit2 blocks rate pin
// R6: 0x0e bit5 automatic idle, else manual
// R7: manual idle: bit4 one mutes output
// R8: 0x0e bit1 auto rate, else bit0 forces
// R9: equalizer enable, gain stage, boost fields
// R10: equalizer resets to 0x20 bypass
// R11: strap pairs map to fixed equalizer codes
// R12: swing field defaults 0x03, 600 mV
// R13: software writes zero to reserved bits
// R14: reset bit reads back zero afterward
// R15: mode strap high enables smbus access
// R16: write: address, register, data, each acked
// R17: read: register, restart, data, host nacks
module rlcr_regbank (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_scl,              // smbus clock pin
	input  wire logic       i_sda,              // smbus data pin level
	output logic            o_sda_out,          // always low when driven
	output logic            o_sda_oe,           // high while pulling sda low
	input  wire logic [3:0] i_addr_strap,       // slave address straps
	input  wire logic       i_smbus_mode_strap, // high: smbus mode
	input  wire logic [1:0] i_eq_strap_high,    // three-level strap code
	input  wire logic [1:0] i_eq_strap_low,     // three-level strap code
	input  wire logic       i_power_down_pin,   // high: power down all lanes
	input  wire logic       i_idle_pin_auto,    // idle pin floating
	input  wire logic       i_idle_pin_mute,    // idle pin forces mute
	input  wire logic       i_rate_pin_auto,    // rate pin floating
	input  wire logic       i_rate_pin_fast,    // rate pin forces 5.0 Gbps
	input  wire logic       i_b_lane0_idle_det, // detector: no signal
	input  wire logic       i_b_lane0_rate_det, // detector: fast rate
	output logic [7:0]      o_lane_power_down,  // a3..a0, b3..b0
	output logic            o_b_output_lane0_mute,
	output logic            o_b_lane0_rate_fast,
	output logic            o_b_input_lane0_eq_en,
	output logic [1:0]      o_gain_stage_field,
	output logic [2:0]      o_boost_level_field,
	output logic [6:0]      o_output_swing
);

	// ************************************************************
	// pin synchronisation
	// ************************************************************
	localparam int SYNC_W = 18;
	logic [SYNC_W-1:0] pins_s;   // synchronised pin levels
	logic              scl_s;
	logic              sda_s;
	logic              pd_pin_s;
	logic              idle_auto_pin_s;
	logic              idle_mute_pin_s;
	logic              rate_auto_pin_s;
	logic              rate_fast_pin_s;
	logic              idle_det_s;
	logic              rate_det_s;
	logic              mode_s;
	logic [3:0]        ad_s;
	logic [1:0]        eqh_s;
	logic [1:0]        eql_s;

	rlcr_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_async    ({i_scl, i_sda, i_power_down_pin, i_idle_pin_auto, i_idle_pin_mute,
		              i_rate_pin_auto, i_rate_pin_fast, i_b_lane0_idle_det, i_b_lane0_rate_det,
		              i_smbus_mode_strap, i_addr_strap, i_eq_strap_high, i_eq_strap_low}),
		.o_sync     (pins_s)
	);

	assign {scl_s, sda_s, pd_pin_s, idle_auto_pin_s, idle_mute_pin_s, rate_auto_pin_s,
	        rate_fast_pin_s, idle_det_s, rate_det_s, mode_s, ad_s, eqh_s, eql_s} = pins_s;

	// ************************************************************
	// bus condition detection
	// ************************************************************
	logic scl_d_r; // previous synchronised scl
	logic sda_d_r; // previous synchronised sda
	wire  scl_rise = scl_s & ~scl_d_r;
	wire  scl_fall = ~scl_s & scl_d_r;
	wire  bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;  // sda falls, scl high
	wire  bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;  // sda rises, scl high

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// ************************************************************
	// byte protocol engine
	// ************************************************************
	typedef enum logic [9:0] {
		ST_IDLE      = 10'h001,
		ST_ADDR      = 10'h002,
		ST_ACK_ADDR  = 10'h004,
		ST_REG       = 10'h008,
		ST_ACK_REG   = 10'h010,
		ST_WDATA     = 10'h020,
		ST_ACK_WDATA = 10'h040,
		ST_RDATA     = 10'h080,
		ST_HOST_ACK  = 10'h100,
		ST_IGNORE    = 10'h200
	} rlcr_state_t;

	rlcr_state_t state_r;     // protocol state
	logic [7:0]  shreg_r;     // shift register, in and out
	logic [3:0]  cnt_r;       // bits moved in the current byte
	logic [7:0]  ptr_r;       // register pointer
	logic        rw_r;        // read requested
	logic        nack_r;      // host answer after a read byte
	logic        drive_r;     // pulling sda low
	logic [7:0]  rdata;       // read mux output

	wire byte_done = (cnt_r == 4'h8);
	wire addr_hit  = (shreg_r[7:1] == {rlcr_pkg::SLAVE_ADDR_HI, ad_s});
	wire wr_stb    = scl_fall & (state_r == ST_WDATA) & byte_done; // data byte complete

	// bus walk; a foreign address or a finished transfer parks in ignore
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b || !mode_s) begin // R15
			state_r <= ST_IDLE;
			drive_r <= 1'b0;
			cnt_r   <= 4'h0;
			shreg_r <= 8'h00;
			ptr_r   <= 8'h00;
			rw_r    <= 1'b0;
			nack_r  <= 1'b1;
		end else if (bus_start) begin // fresh or repeated start
			state_r <= ST_ADDR;
			drive_r <= 1'b0;
			cnt_r   <= 4'h0;
		end else if (bus_stop) begin
			state_r <= ST_IDLE;
			drive_r <= 1'b0;
		end else if (scl_rise) begin
			if (state_r == ST_ADDR || state_r == ST_REG || state_r == ST_WDATA) begin
				shreg_r <= {shreg_r[6:0], sda_s};
				cnt_r   <= cnt_r + 4'h1;
			end else if (state_r == ST_HOST_ACK) begin
				nack_r <= sda_s; // R17
			end
		end else if (scl_fall) begin
			case (state_r)
				ST_ADDR: begin
					if (byte_done && addr_hit) begin
						state_r <= ST_ACK_ADDR;
						drive_r <= 1'b1; // R16
						rw_r    <= shreg_r[0];
					end else if (byte_done) begin
						state_r <= ST_IGNORE;
					end
				end
				ST_REG: begin
					if (byte_done) begin
						state_r <= ST_ACK_REG;
						drive_r <= 1'b1; // R16
						ptr_r   <= shreg_r;
					end
				end
				ST_WDATA: begin
					if (byte_done) begin
						state_r <= ST_ACK_WDATA;
						drive_r <= 1'b1; // R16
					end
				end
				ST_ACK_ADDR, ST_HOST_ACK: begin
					if (state_r == ST_HOST_ACK && nack_r) begin
						state_r <= ST_IGNORE; // R17
						drive_r <= 1'b0;
					end else if (rw_r) begin
						state_r <= ST_RDATA;
						drive_r <= ~rdata[7];
						shreg_r <= {rdata[6:0], 1'b0};
						cnt_r   <= 4'h1;
					end else begin
						state_r <= ST_REG;
						drive_r <= 1'b0;
						cnt_r   <= 4'h0;
					end
				end
				ST_ACK_REG: begin
					state_r <= ST_WDATA;
					drive_r <= 1'b0;
					cnt_r   <= 4'h0;
				end
				ST_ACK_WDATA: begin
					state_r <= ST_IGNORE; // one data byte per write
					drive_r <= 1'b0;
				end
				ST_RDATA: begin
					if (byte_done) begin
						state_r <= ST_HOST_ACK;
						drive_r <= 1'b0;
					end else begin
						drive_r <= ~shreg_r[7];
						shreg_r <= {shreg_r[6:0], 1'b0};
						cnt_r   <= cnt_r + 4'h1;
					end
				end
				default: begin
					drive_r <= 1'b0;
				end
			endcase
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe  = drive_r;

	// ************************************************************
	// register file
	// ************************************************************
	logic [7:0] lane_pd_r;   // lane_power_down
	logic [7:0] pd_src_r;    // power_down_source
	logic [7:0] ovr_r;       // strap_override
	logic [7:0] ctl_r;       // lane0_b_idle_rate_ctrl
	logic [7:0] eq_r;        // lane0_b_equalizer
	logic [7:0] swing_r;     // lane0_b_output_swing

	// the reset bit is never stored, so it always reads back zero
	wire soft_rst = wr_stb & (ptr_r == rlcr_pkg::OFF_SOFT_RST) & shreg_r[rlcr_pkg::BIT_SOFT_RST]; // R14

	// reserved bits are masked away, so stray ones in them are harmless
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b || soft_rst) begin // R1
			lane_pd_r <= rlcr_pkg::RST_LANE_PD;
			pd_src_r  <= rlcr_pkg::RST_PD_SRC;
			ovr_r     <= rlcr_pkg::RST_OVERRIDE;
			ctl_r     <= rlcr_pkg::RST_IDLE_RATE;
			eq_r      <= rlcr_pkg::RST_EQ; // R10
			swing_r   <= rlcr_pkg::RST_SWING; // R12
		end else if (wr_stb) begin
			case (ptr_r)
				rlcr_pkg::OFF_LANE_PD:   lane_pd_r <= shreg_r & rlcr_pkg::MSK_LANE_PD; // R2
				rlcr_pkg::OFF_PD_SRC:    pd_src_r  <= shreg_r & rlcr_pkg::MSK_PD_SRC;
				rlcr_pkg::OFF_OVERRIDE:  ovr_r     <= shreg_r & rlcr_pkg::MSK_OVERRIDE;
				rlcr_pkg::OFF_IDLE_RATE: ctl_r     <= shreg_r & rlcr_pkg::MSK_IDLE_RATE;
				rlcr_pkg::OFF_EQ:        eq_r      <= shreg_r & rlcr_pkg::MSK_EQ; // R9
				rlcr_pkg::OFF_SWING:     swing_r   <= shreg_r & rlcr_pkg::MSK_SWING;
				default: begin
				end
			endcase
		end
	end

	// unmapped offsets and the reset register read as zero
	assign rdata = (ptr_r == rlcr_pkg::OFF_LANE_PD)   ? lane_pd_r :
	               (ptr_r == rlcr_pkg::OFF_PD_SRC)    ? pd_src_r  :
	               (ptr_r == rlcr_pkg::OFF_OVERRIDE)  ? ovr_r     :
	               (ptr_r == rlcr_pkg::OFF_IDLE_RATE) ? ctl_r     :
	               (ptr_r == rlcr_pkg::OFF_EQ)        ? eq_r      :
	               (ptr_r == rlcr_pkg::OFF_SWING)     ? swing_r   : 8'h00;

	// ************************************************************
	// pin versus register arbitration
	// ************************************************************
	wire       pd_block   = pd_src_r[rlcr_pkg::BIT_PD_BLOCK];
	wire [7:0] pd_nxt     = pd_block ? lane_pd_r : (lane_pd_r | {8{pd_pin_s}}); // R3
	wire       idle_ovr   = ovr_r[rlcr_pkg::BIT_OVR_IDLE];
	wire       idle_auto  = idle_ovr ? ctl_r[rlcr_pkg::BIT_IDLE_AUTO] : idle_auto_pin_s; // R4
	wire       idle_man   = idle_ovr ? ctl_r[rlcr_pkg::BIT_IDLE_MUTE] : idle_mute_pin_s;
	wire       mute_nxt   = idle_auto ? idle_det_s : idle_man; // R6 R7
	wire       rate_ovr   = ovr_r[rlcr_pkg::BIT_OVR_RATE];
	wire       rate_auto  = rate_ovr ? ctl_r[rlcr_pkg::BIT_RATE_AUTO] : rate_auto_pin_s; // R5
	wire       rate_man   = rate_ovr ? ctl_r[rlcr_pkg::BIT_RATE_FAST] : rate_fast_pin_s;
	wire       fast_nxt   = rate_auto ? rate_det_s : rate_man; // R8
	wire [7:0] eq_nxt     = mode_s ? eq_r : rlcr_pkg::eq_from_straps(eqh_s, eql_s); // R11

	// registered controls toward the analog lanes
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			o_lane_power_down     <= rlcr_pkg::RST_LANE_PD;
			o_b_output_lane0_mute <= 1'b0;
			o_b_lane0_rate_fast   <= 1'b0;
			{o_b_input_lane0_eq_en, o_gain_stage_field, o_boost_level_field} <= rlcr_pkg::RST_EQ[5:0];
			o_output_swing        <= rlcr_pkg::RST_SWING[6:0];
		end else begin
			o_lane_power_down     <= pd_nxt;
			o_b_output_lane0_mute <= mute_nxt;
			o_b_lane0_rate_fast   <= fast_nxt;
			{o_b_input_lane0_eq_en, o_gain_stage_field, o_boost_level_field} <= eq_nxt[5:0]; // R9
			o_output_swing        <= swing_r[6:0];
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_soft_rst;
		wr_stb && ptr_r == rlcr_pkg::OFF_SOFT_RST && shreg_r[0];
	endsequence

	sequence s_pd_write;
		wr_stb && ptr_r == rlcr_pkg::OFF_LANE_PD;
	endsequence

	chk_soft_reset_defaults: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R1
		s_soft_rst |=> (lane_pd_r == 8'h00 && pd_src_r == 8'h00 && ovr_r == 8'h00 && ctl_r == 8'h00 &&
		                eq_r == 8'h20 && swing_r == 8'h03))
		else $error("soft reset left a register off its default");

	chk_reset_bit_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R14
		s_soft_rst ##1 (ptr_r == 8'h00) |-> rdata == 8'h00)
		else $error("reset register did not read back zero");

	chk_pd_write_lands: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R2
		s_pd_write |=> lane_pd_r == $past(shreg_r))
		else $error("power-down register missed its write");

	chk_pd_pin_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R3
		(pd_block && lane_pd_r == 8'h00) ##1 (pd_block && lane_pd_r == 8'h00) |-> o_lane_power_down == 8'h00)
		else $error("blocked power-down pin still acted");

	chk_idle_pin_path: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R4
		(!idle_ovr && !idle_auto_pin_s) |=> o_b_output_lane0_mute == $past(idle_mute_pin_s))
		else $error("idle pin did not steer mute");

	chk_manual_mute: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R7
		(idle_ovr && !ctl_r[5]) |=> o_b_output_lane0_mute == $past(ctl_r[4]))
		else $error("manual idle bit not applied");

	chk_auto_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R6
		(idle_ovr && ctl_r[5]) |=> o_b_output_lane0_mute == $past(idle_det_s))
		else $error("automatic idle not following detector");

	chk_forced_rate: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R8
		(rate_ovr && !ctl_r[1]) |=> o_b_lane0_rate_fast == $past(ctl_r[0]))
		else $error("forced rate not applied");

	chk_rate_pin_path: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R5
		(!rate_ovr && !rate_auto_pin_s) |=> o_b_lane0_rate_fast == $past(rate_fast_pin_s))
		else $error("rate pin did not steer rate");

	chk_eq_reset_value: assert property (@(posedge i_core_clk) // R10
		!i_rst_b |=> eq_r == 8'h20 && swing_r == 8'h03)
		else $error("equalizer or swing reset value wrong");

	chk_addr_ack_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R16
		(mode_s && scl_fall && !bus_start && !bus_stop && state_r == ST_ADDR && byte_done && addr_hit)
		|=> o_sda_oe ##1 (o_sda_oe || bus_start || bus_stop || !mode_s))
		else $error("address byte not acknowledged");

endmodule

`default_nettype wire

/* rtl/rlcr_sync.sv */
/*
 * two flip-flop synchroniser for a vector of unrelated pin levels.
 * assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ns
`default_nettype none

module rlcr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	// ************************************************************
	// two stages; the first is read only by the second
	// ************************************************************
	logic [WIDTH-1:0] meta_r; // first stage, may go metastable

	// capture then settle
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule

`default_nettype wire

/* testbench/repeater_lane_config_regs_test.sv */
/* self-checking bench of the lane configuration register bank.
 * assumes the host model drives scl and pulls sda; sda has a pull-up. */
`timescale 1ns/1ns
`default_nettype none
module repeater_lane_config_regs_test;
	localparam logic [7:0] DEV = {rlcr_pkg::SLAVE_ADDR_HI, 4'h3, 1'b0}; // straps at 3
	logic clk = 1'b0, rst_b = 1'b0, scl, host_low, sda_oe, sda_out, mute, fast, eq_en;
	logic mode = 1'b1;
	logic pd_pin = 1'b0, idle_auto = 1'b0, idle_mute = 1'b0, rate_auto = 1'b0, rate_fast = 1'b0;
	logic idle_det = 1'b0, rate_det = 1'b0;
	logic [1:0] eq_hi = 2'h0, eq_lo = 2'h0, gain_stage;
	logic [2:0] boost_level;
	logic [6:0] swing;
	logic [7:0] pd;
	logic [7:0] offs [7] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0e, 8'h0f, 8'h10};
	logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h03};
	logic [7:0] wmsk [7] = '{8'h00, 8'hff, 8'h01, 8'h14, 8'h33, 8'h3f, 8'h7f};
	// {override, idle/rate reg, pins, detectors, expected mute and rate}
	logic [23:0] irt [7] = '{24'h14000c, 24'h1411f3, 24'h14220f, 24'h142250, 24'h00110c, 24'h0000af, 24'h000053};
	// {strap high code, strap low code, expected equalizer}
	logic [11:0] eqt [9] = '{12'h52a, 12'h030, 12'h832, 12'h439, 12'h935, 12'h137, 12'h23b, 12'h63d, 12'ha20};
	int err_count = 0;
	int check_count = 0;
	wire logic sda;
	assign sda = !host_low && (sda_oe ? sda_out : 1'b1); // pull-up unless pulled
	always #10 clk = ~clk;
	rlcr_regbank u_dut (
		.i_core_clk           (clk),
		.i_rst_b              (rst_b),
		.i_scl                (scl),
		.i_sda                (sda),
		.o_sda_out            (sda_out),
		.o_sda_oe             (sda_oe),
		.i_addr_strap         (4'h3),
		.i_smbus_mode_strap   (mode),
		.i_eq_strap_high      (eq_hi),
		.i_eq_strap_low       (eq_lo),
		.i_power_down_pin     (pd_pin),
		.i_idle_pin_auto      (idle_auto),
		.i_idle_pin_mute      (idle_mute),
		.i_rate_pin_auto      (rate_auto),
		.i_rate_pin_fast      (rate_fast),
		.i_b_lane0_idle_det   (idle_det),
		.i_b_lane0_rate_det   (rate_det),
		.o_lane_power_down    (pd),
		.o_b_output_lane0_mute(mute),
		.o_b_lane0_rate_fast  (fast),
		.o_b_input_lane0_eq_en(eq_en),
		.o_gain_stage_field   (gain_stage),
		.o_boost_level_field  (boost_level),
		.o_output_swing       (swing)
	);
	rlcr_smbus_host u_host (
		.i_core_clk(clk),
		.i_sda     (sda),
		.o_scl     (scl),
		.o_sda_low (host_low)
	);
	// ********
	// compare, access and wait tasks
	// ********
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		logic [2:0] a;
		u_host.wr_reg(DEV, off, d, a);
		chk({5'h0, a}, 8'h00);
	endtask
	task automatic rd(input logic [7:0] off, input logic [7:0] exp);
		logic [2:0] a;
		logic [7:0] d;
		u_host.rd_reg(DEV, off, d, a);
		chk({5'h0, a}, 8'h00);
		chk(d, exp);
	endtask
	// outputs trail pins by three edges; five leaves margin
	task automatic settle();
		repeat (5) @(posedge clk);
	endtask
	task automatic rd_all();
		for (int i = 0; i < 7; i++) begin
			rd(offs[i], rstv[i]);
		end
		chk({2'h0, eq_en, gain_stage, boost_level}, 8'h20);
		chk({1'b0, swing}, 8'h03);
		chk(pd, 8'h00);
	endtask
	task automatic tally_and_finish();
		if (err_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// a hung run counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	// ********
	// main sequence
	// ********
	initial begin
		logic [2:0] a;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rd_all();
		// only writable bits set, reserved bits kept zero
		for (int i = 1; i < 7; i++) begin
			wr(offs[i], wmsk[i]);
			rd(offs[i], wmsk[i]);
		end
		settle();
		chk(pd, 8'hff);
		chk({2'h0, eq_en, gain_stage, boost_level}, 8'h3f);
		pd_pin <= 1'b1;
		wr(8'h01, 8'h00);
		settle();
		chk(pd, 8'h00);
		wr(8'h01, 8'ha5);
		settle();
		chk(pd, 8'ha5);
		wr(8'h02, 8'h00);
		settle();
		chk(pd, 8'hff);
		pd_pin <= 1'b0;
		settle();
		chk(pd, 8'ha5);
		for (int i = 0; i < 7; i++) begin
			wr(8'h08, irt[i][23:16]);
			wr(8'h0e, irt[i][15:8]);
			{idle_auto, idle_mute, rate_auto, rate_fast, idle_det, rate_det} <= irt[i][7:2];
			settle();
			chk({6'h0, mute, fast}, {6'h0, irt[i][1:0]});
		end
		wr(8'h0f, 8'h1a);
		settle();
		chk({2'h0, eq_en, gain_stage, boost_level}, 8'h1a);
		wr(8'h10, 8'h0f);
		settle();
		chk({1'b0, swing}, 8'h0f);
		u_host.wr_reg(DEV ^ 8'h02, 8'h10, 8'h07, a);
		chk({5'h0, a}, 8'h07);
		rd(8'h10, 8'h0f);
		rd(8'h05, 8'h00);
		wr(8'h00, 8'h01);
		rd_all();
		mode <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			{eq_hi, eq_lo} <= eqt[i][11:8];
			settle();
			chk({2'h0, eq_en, gain_stage, boost_level}, eqt[i][7:0]);
		end
		// with the mode strap low nothing may be acknowledged or stored
		u_host.wr_reg(DEV, 8'h10, 8'h07, a);
		chk({5'h0, a}, 8'h07);
		mode <= 1'b1;
		settle();
		rd(8'h10, 8'h03);
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* testbench/rlcr_smbus_host.sv */
/* smbus host model: single-byte register writes and reads, bit by bit.
 * assumes the bench resolves sda with a pull-up and feeds the level back. */
`timescale 1ns/1ns
`default_nettype none
module rlcr_smbus_host (
	input  wire logic i_core_clk,
	input  wire logic i_sda,     // resolved wire level
	output logic      o_scl,     // push-pull, never stretched
	output logic      o_sda_low  // high: host pulls sda low
);
	localparam int HALF = 10; // scl phase in core cycles, well above the slave minimum
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// ********
	// bit level
	// ********
	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// data moves two cycles after scl falls, so it never reads as start or stop
	task automatic bit_io(input logic b, output logic s);
		tick(2);
		o_sda_low <= !b;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		s = i_sda;
		o_scl <= 1'b0;
	endtask
	// eight bits msb first, then the ninth (ack) bit
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(ack_in, ack);
	endtask
	// also a repeated start: scl is low on entry after an ack
	task automatic start_cond();
		tick(2);
		o_sda_low <= 1'b0;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b0;
	endtask
	task automatic stop_cond();
		tick(2);
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b0;
		tick(HALF);
	endtask
	// ********
	// register level; acks bit low means acknowledged
	// ********
	task automatic wr_reg(input logic [7:0] dev, input logic [7:0] off, input logic [7:0] d, output logic [2:0] acks);
		logic [7:0] q;
		start_cond();
		xfer(dev, 1'b1, q, acks[2]);
		xfer(off, 1'b1, q, acks[1]);
		xfer(d, 1'b1, q, acks[0]);
		stop_cond();
	endtask
	task automatic rd_reg(input logic [7:0] dev, input logic [7:0] off, output logic [7:0] d, output logic [2:0] acks);
		logic [7:0] q;
		logic a;
		start_cond();
		xfer(dev, 1'b1, q, acks[2]);
		xfer(off, 1'b1, q, acks[1]);
		start_cond();
		xfer(dev | 8'h01, 1'b1, q, acks[0]);
		xfer(8'hff, 1'b1, d, a);
		stop_cond();
	endtask
endmodule
`default_nettype wire
